// file: rtl/prc_defines.svh
// Purpose: constants of the pump remote contact block
// Assumes: pclk at 10 MHz
// Notes: times kept in ms, cycle counts derived from them
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH
// Clock rate in kHz
`define PRC_CLK_KHZ 10000
// Power-up settle, mains interruption limit, contact debounce
`define PRC_POWERUP_MS 6000
`define PRC_PFAIL_MS 1000
`define PRC_DEBOUNCE_MS 1
`define PRC_POWERUP_CYC (`PRC_POWERUP_MS * `PRC_CLK_KHZ)
`define PRC_PFAIL_CYC (`PRC_PFAIL_MS * `PRC_CLK_KHZ)
`define PRC_DEBOUNCE_CYC (`PRC_DEBOUNCE_MS * `PRC_CLK_KHZ)
// Register byte offsets
`define PRC_OFF_CFG 8'h00
`define PRC_OFF_CMD 8'h04
`define PRC_OFF_STAT 8'h08
`define PRC_OFF_RCNT 8'h0C
// Configuration field positions and reset value
`define PRC_CFG_ALLMODE 0
`define PRC_CFG_POL_ALM 1
`define PRC_CFG_POL_WRN 2
`define PRC_CFG_POL_REM 3
`define PRC_CFG_RST 4'hE
// Command field positions
`define PRC_CMD_START 0
`define PRC_CMD_STOP 1
`endif

// file: rtl/prc_pkg.sv
// Purpose: types of the pump remote contact block
// Assumes: nothing
// Notes: contacts are low when shorted to ground
package prc_pkg;
  // Pump sequencing states
  typedef enum logic [2:0] {ST_IDLE, ST_ACCEL, ST_RUN, ST_BRAKE,
    ST_PFAIL} prc_state_t;
  // One changeover relay: make and break contact, 1 = closed
  typedef struct packed {
    logic make;
    logic brk;
  } prc_pair_t;
  // All relay outputs
  typedef struct packed {
    prc_pair_t rotor_turning_out;
    prc_pair_t at_speed;
    prc_pair_t accel;
    prc_pair_t brake;
    prc_pair_t remote;
    prc_pair_t alarm;
    prc_pair_t warning;
  } prc_relays_t;
  // Contact inputs, active low
  typedef struct packed {
    logic start_n;
    logic stop_n;
    logic reset_n;
    logic low_n;
  } prc_contacts_t;
endpackage

// file: rtl/prc_remote_io.sv
// Purpose: remote contact inputs and relay outputs of a pump controller
// Assumes: contacts asynchronous to pclk; APB register access
// Notes: relay outputs stay de-energised until the power-up delay ends
`timescale 1ns/1ns
`include "prc_defines.svh"
module prc_remote_io
  import prc_pkg::*;
#(
  parameter int POWERUP_CYC = `PRC_POWERUP_CYC,
  parameter int PFAIL_CYC = `PRC_PFAIL_CYC,
  parameter int DEB_CYC = `PRC_DEBOUNCE_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire prc_contacts_t contacts,
  input wire logic panel_remote,
  input wire logic local_start,
  input wire logic local_stop,
  input wire logic rotor_turning,
  input wire logic rotor_at_speed,
  input wire logic mains_ok,
  input wire logic fault_active,
  input wire logic warning_active,
  output prc_relays_t relays,
  output logic motor_accel,
  output logic motor_brake,
  output logic motor_low_speed,
  output logic fault_reset,
  output logic regen_brake
);

////////////////////////////////////////////////////////////////////////
// Contact conditioning

logic [3:0] sync1_r; // First stage, read only by second
logic [3:0] sync2_r; // Second stage
logic [3:0] deb; // Debounced levels, 1 = open

// Two-flop synchroniser, open contacts at reset
always_ff @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    sync1_r <= 4'hF;
    sync2_r <= 4'hF;
  end
  else
  begin
    sync1_r <= contacts;
    sync2_r <= sync1_r;
  end
end

genvar gi;
generate
  for (gi = 0; gi < 4; gi++)
  begin : g_deb
    logic [31:0] cnt_r; // Stable-time counter
    logic stable_r; // Accepted level
    // Level must hold a full debounce time to be accepted
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        cnt_r <= 32'h0;
        stable_r <= 1'b1;
      end
      else if (sync2_r[gi] == stable_r)
        cnt_r <= 32'h0;
      else if (cnt_r >= 32'(DEB_CYC - 1))
      begin
        stable_r <= sync2_r[gi];
        cnt_r <= 32'h0;
      end
      else
        cnt_r <= cnt_r + 32'h1;
    end
    assign deb[gi] = stable_r;
  end
endgenerate

logic start_cl; // Start shorted
logic stop_open; // Stop open, fail-safe request
logic reset_cl; // Reset shorted
logic low_cl; // Reduced speed shorted
assign start_cl = ~deb[3];
assign stop_open = deb[2];
assign reset_cl = ~deb[1];
assign low_cl = ~deb[0];

////////////////////////////////////////////////////////////////////////
// Register interface

logic [3:0] cfg_r; // Configuration
logic [15:0] rcnt_r; // Reset closures seen
logic pready_r;
logic pslverr_r;
logic [31:0] prdata_r;
logic wr_acc; // Write in access phase
logic ser_start; // Serial start command pulse
logic ser_stop; // Serial stop command pulse
logic addr_ok; // Address decodes
logic [31:0] rd_val; // Read mux

prc_state_t state_r;
logic alarm_r;
logic run_req_r;
logic pwr_ok_r;

assign addr_ok = (paddr == `PRC_OFF_CFG) || (paddr == `PRC_OFF_CMD) ||
  (paddr == `PRC_OFF_STAT) || (paddr == `PRC_OFF_RCNT);
assign wr_acc = psel && penable && pwrite && pready_r;
assign ser_start = wr_acc && (paddr == `PRC_OFF_CMD) &&
  pwdata[`PRC_CMD_START];
assign ser_stop = wr_acc && (paddr == `PRC_OFF_CMD) &&
  pwdata[`PRC_CMD_STOP];

// Read mux, unmapped and command words read zero
always_comb
begin
  rd_val = 32'h0;
  unique case (paddr)
    `PRC_OFF_CFG: rd_val = {28'h0, cfg_r};
    `PRC_OFF_STAT: rd_val = {24'h0, mains_ok, pwr_ok_r, alarm_r,
      run_req_r, 1'b0, state_r};
    `PRC_OFF_RCNT: rd_val = {16'h0, rcnt_r};
    default: rd_val = 32'h0;
  endcase
end

// Zero-wait slave: answer ready in the first access cycle
always_ff @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    pready_r <= 1'b0;
    pslverr_r <= 1'b0;
    prdata_r <= 32'h0;
  end
  else
  begin
    pready_r <= psel && !penable;
    pslverr_r <= psel && !penable && !addr_ok;
    if (psel && !penable && !pwrite)
      prdata_r <= rd_val;
  end
end

// Configuration word selects signal behaviour
always_ff @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    cfg_r <= `PRC_CFG_RST;
  else if (wr_acc && paddr == `PRC_OFF_CFG)
    cfg_r <= pwdata[3:0];
end

////////////////////////////////////////////////////////////////////////
// Power-up delay and reset contact

logic [31:0] pu_cnt_r; // Power-up timer
logic reset_cl_d_r; // Previous reset level
logic rst_edge; // Closing edge of reset contact

// Relay outputs are held invalid until the controller has settled
always_ff @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    pu_cnt_r <= 32'h0;
    pwr_ok_r <= 1'b0;
  end
  else if (!pwr_ok_r)
  begin
    pu_cnt_r <= pu_cnt_r + 32'h1;
    pwr_ok_r <= pu_cnt_r >= 32'(POWERUP_CYC - 1);
  end
end

assign rst_edge = reset_cl && !reset_cl_d_r;

// One pulse and one count per closure; holding it gives nothing more
always_ff @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    reset_cl_d_r <= 1'b0;
    fault_reset <= 1'b0;
    rcnt_r <= 16'h0;
  end
  else
  begin
    reset_cl_d_r <= reset_cl;
    fault_reset <= rst_edge;
    if (rst_edge)
      rcnt_r <= rcnt_r + 16'h1;
  end
end

// Alarm latch; a new fault wins over a reset in the same cycle
always_ff @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    alarm_r <= 1'b0;
  else if (fault_active)
    alarm_r <= 1'b1;
  else if (fault_reset)
    alarm_r <= 1'b0;
end

////////////////////////////////////////////////////////////////////////
// Run request

logic remote_avail; // Remote mode selected and settled
logic stop_eff; // Stop contact is honoured now
logic run_set;
logic run_clr;
logic [31:0] pf_cnt_r; // Outage timer
logic pf_long; // Outage beyond the ride-through limit

assign remote_avail = panel_remote && pwr_ok_r;
// Stop acts in remote, or outside remote too (local and serial) when interlock is set
assign stop_eff = stop_open && (remote_avail ||
  (cfg_r[`PRC_CFG_ALLMODE] && !panel_remote));
// Remote mode ignores local switches and serial commands
assign run_set = panel_remote ? (remote_avail && start_cl)
  : (local_start || ser_start);
assign run_clr = stop_eff || alarm_r || pf_long ||
  (!panel_remote && (local_stop || ser_stop));
assign pf_long = (state_r == ST_PFAIL) &&
  (pf_cnt_r >= 32'(PFAIL_CYC - 1));

// Clear has priority so a stop always beats a start
always_ff @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    run_req_r <= 1'b0;
  else if (run_clr)
    run_req_r <= 1'b0;
  else if (run_set)
    run_req_r <= 1'b1;
end

////////////////////////////////////////////////////////////////////////
// Pump sequencing

prc_state_t state_nxt;
logic run_go; // Request not blocked by alarm

assign run_go = run_req_r && !alarm_r;

// Next state; mains loss overrides everything
always_comb
begin
  state_nxt = state_r;
  if (!mains_ok)
    state_nxt = ST_PFAIL;
  else
  begin
    unique case (state_r)
      ST_IDLE:
        if (run_go)
          state_nxt = ST_ACCEL;
      ST_ACCEL:
        if (!run_go)
          state_nxt = ST_BRAKE;
        else if (rotor_at_speed)
          state_nxt = ST_RUN;
      ST_RUN:
        if (!run_go)
          state_nxt = ST_BRAKE;
      ST_BRAKE:
        if (run_go)
          state_nxt = ST_ACCEL;
        else if (!rotor_turning)
          state_nxt = ST_IDLE;
      // Short outage: request kept, so running resumes
      ST_PFAIL:
        state_nxt = run_go ? ST_ACCEL : ST_BRAKE;
      default:
        state_nxt = ST_BRAKE;
    endcase
  end
end

// State register
always_ff @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    state_r <= ST_IDLE;
  else
    state_r <= state_nxt;
end

// Outage timer; past the limit the run request is dropped
always_ff @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    pf_cnt_r <= 32'h0;
  else if (state_r != ST_PFAIL)
    pf_cnt_r <= 32'h0;
  else if (!pf_long)
    pf_cnt_r <= pf_cnt_r + 32'h1;
end

// Motor commands; regenerated energy keeps the bearings levitated
always_ff @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    motor_accel <= 1'b0;
    motor_brake <= 1'b0;
    motor_low_speed <= 1'b0;
    regen_brake <= 1'b0;
  end
  else
  begin
    motor_accel <= state_nxt == ST_ACCEL;
    motor_brake <= state_nxt == ST_BRAKE;
    motor_low_speed <= low_cl;
    regen_brake <= state_nxt == ST_PFAIL;
  end
end

////////////////////////////////////////////////////////////////////////
// Relay outputs

// Energised pair: make closed, break open; idle while settling
function automatic prc_pair_t pair_of(input logic act, input logic ok);
  pair_of = {act && ok, !(act && ok)};
endfunction

logic alm_act; // Alarm relay drive after polarity
logic wrn_act; // Warning relay drive after polarity
logic rem_act; // Remote relay drive after polarity

// Native polarity energises on the event; the other on health
assign alm_act = cfg_r[`PRC_CFG_POL_ALM] ? alarm_r : !alarm_r;
assign wrn_act = cfg_r[`PRC_CFG_POL_WRN] ? warning_active
  : !warning_active;
// Native remote relay drops during regenerative braking
assign rem_act = remote_avail && !(cfg_r[`PRC_CFG_POL_REM] &&
  state_r == ST_PFAIL);

// All relays registered, de-energised until power-up ends
always_ff @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    relays <= prc_relays_t'(14'h1555);
  else
  begin
    relays.rotor_turning_out <= pair_of(rotor_turning, pwr_ok_r);
    relays.at_speed <= pair_of(rotor_at_speed, pwr_ok_r);
    relays.accel <= pair_of(state_r == ST_ACCEL, pwr_ok_r);
    relays.brake <= pair_of(state_r == ST_BRAKE ||
      state_r == ST_PFAIL, pwr_ok_r);
    relays.remote <= pair_of(rem_act, pwr_ok_r);
    relays.alarm <= pair_of(alm_act, pwr_ok_r);
    relays.warning <= pair_of(wrn_act, pwr_ok_r);
  end
end

assign prdata = prdata_r;
assign pready = pready_r;
assign pslverr = pslverr_r;

////////////////////////////////////////////////////////////////////////
// Assertions

default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);

sequence s_mains_lost;
  $fell(mains_ok);
endsequence

sequence s_regen_entered;
  state_r == ST_PFAIL ##0 regen_brake;
endsequence

a_stop_clears_run: assert property (
  stop_eff |=> !run_req_r) else $error("stop did not clear run");
a_stop_beats_start: assert property (
  stop_eff && start_cl |=> !motor_accel || $past(motor_accel))
  else $error("start accepted against stop");
a_reset_single: assert property (
  fault_reset |=> !fault_reset ##1 !fault_reset)
  else $error("reset pulse repeated");
a_powerup_quiet: assert property (
  !pwr_ok_r |=> !relays.alarm.make && !relays.remote.make)
  else $error("relay active before power-up end");
a_mains_regen: assert property (
  s_mains_lost |=> s_regen_entered) else $error("no regen braking");
a_rotor_pair: assert property (
  rotor_turning && pwr_ok_r |=> relays.rotor_turning_out == 2'b10)
  else $error("rotation relay wrong");
a_low_speed: assert property (
  low_cl |=> motor_low_speed) else $error("low speed not applied");
a_alarm_blocks: assert property (
  alarm_r && state_r != ST_ACCEL |=> state_r != ST_ACCEL)
  else $error("accelerated with alarm latched");
a_remote_local: assert property (
  panel_remote && !start_cl |=> !$rose(run_req_r))
  else $error("local start honoured in remote");

endmodule

// file: tb/prc_host_model.sv
// Purpose: host equipment driving the remote contact inputs
// Assumes: requests are levels from the bench, 1 = request made
// Notes: reset closures are whole open-close cycles
`timescale 1ns/1ns
module prc_host_model
  import prc_pkg::*;
(
  input wire logic pclk,
  input wire logic want_start,
  input wire logic want_stop,
  input wire logic want_low,
  output prc_contacts_t contacts
);
  // Reset contact state, closed when high
  logic rst_closed = 1'b0;
  // Shorted contact reads 0; stop line opened means stop wanted
  assign contacts = {~want_start, want_stop, ~rst_closed, ~want_low};
  ////////////////////////////////////////////////////////////////////
  // One closure per call, reopened well past the debounce time
  task automatic press_reset();
    @(posedge pclk);
    rst_closed <= 1'b1;
    repeat (10) @(posedge pclk);
    rst_closed <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask
endmodule

// file: tb/tb.sv
// Purpose: self-checking bench of the remote contact block
// Assumes: shortened counts, power-up 50, outage 40, debounce 3
// Notes: random register values from a fixed-seed xorshift
`timescale 1ns/1ns
module tb;
  import prc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  prc_contacts_t contacts;
  logic panel_remote = 1'b1, local_start = 1'b0, local_stop = 1'b1;
  logic rotor_turning = 1'b0, rotor_at_speed = 1'b0, mains_ok = 1'b1;
  logic fault_active = 1'b0, warning_active = 1'b0;
  logic want_start = 1'b0, want_stop = 1'b1, want_low = 1'b0;
  prc_relays_t relays;
  logic motor_accel, motor_brake, motor_low_speed, fault_reset;
  logic regen_brake;
  int fails = 0, comparisons = 0, pulses = 0, n;
  logic [31:0] seed = 32'h24AFE2DC, v, r0;
  prc_remote_io #(.POWERUP_CYC(50), .PFAIL_CYC(40), .DEB_CYC(3)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contacts(contacts), .panel_remote(panel_remote),
    .local_start(local_start), .local_stop(local_stop),
    .rotor_turning(rotor_turning), .rotor_at_speed(rotor_at_speed),
    .mains_ok(mains_ok), .fault_active(fault_active),
    .warning_active(warning_active), .relays(relays),
    .motor_accel(motor_accel), .motor_brake(motor_brake),
    .motor_low_speed(motor_low_speed), .fault_reset(fault_reset),
    .regen_brake(regen_brake));
  prc_host_model i_host (.pclk(pclk), .want_start(want_start),
    .want_stop(want_stop), .want_low(want_low), .contacts(contacts));
  ////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial
  begin
    forever #50 pclk = ~pclk;
  end
  // Count reset pulses seen by the pump side
  always @(posedge pclk)
  begin
    if (fault_reset === 1'b1)
      pulses++;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Holds the request until pready is sampled high
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    if (k == 50)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic pick(int w);
    case (w)
      0: return motor_accel;
      1: return motor_brake;
      default: return regen_brake;
    endcase
  endfunction
  // Bounded wait for a motor level, then compare
  task automatic wait_lvl(string nm, int w, logic lv, int lim);
    int k;
    k = 0;
    while (pick(w) !== lv && k < lim)
    begin
      @(negedge pclk);
      k++;
    end
    chk(nm, {31'h0, lv}, {31'h0, pick(w)});
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(negedge pclk);
    chk("relays_early", 32'h1555, {18'h0, relays});
    repeat (50) @(negedge pclk);
    chk("remote", 32'h2, {30'h0, relays.remote});
    chk("alarm_ok", 32'h1, {30'h0, relays.alarm});
    apb(1'b0, 8'h00, 32'h0);
    chk("cfg_rst", 32'hE, rd);
    v = rnd() & 32'hF;
    apb(1'b1, 8'h00, v);
    apb(1'b0, 8'h00, 32'h0);
    chk("cfg_rw", v, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 8'h00, 32'hE);
    want_start <= 1'b1;
    local_start <= 1'b1;
    repeat (20) @(negedge pclk);
    chk("accel_stop_wins", 32'h0, {31'h0, motor_accel});
    @(posedge pclk);
    want_stop <= 1'b0;
    local_start <= 1'b0;
    wait_lvl("accel_start", 0, 1'b1, 30);
    @(posedge pclk);
    rotor_turning <= 1'b1;
    want_low <= 1'b1;
    // Low-speed contact needs sync plus debounce before it acts
    repeat (8) @(negedge pclk);
    chk("accel_rel", 32'h2, {30'h0, relays.accel});
    chk("rot_rel", 32'h2, {30'h0, relays.rotor_turning_out});
    chk("low", 32'h1, {31'h0, motor_low_speed});
    @(posedge pclk);
    mains_ok <= 1'b0;
    wait_lvl("regen", 2, 1'b1, 3);
    repeat (2) @(negedge pclk);
    chk("brake_rel", 32'h2, {30'h0, relays.brake});
    @(posedge pclk);
    mains_ok <= 1'b1;
    wait_lvl("resume", 0, 1'b1, 10);
    @(posedge pclk);
    rotor_at_speed <= 1'b1;
    repeat (4) @(negedge pclk);
    chk("speed_rel", 32'h2, {30'h0, relays.at_speed});
    @(posedge pclk);
    want_stop <= 1'b1;
    wait_lvl("stop", 1, 1'b1, 30);
    chk("stop_accel", 32'h0, {31'h0, motor_accel});
    @(posedge pclk);
    want_start <= 1'b0;
    want_stop <= 1'b0;
    rotor_at_speed <= 1'b0;
    // Local start must stay ignored while the panel selects remote
    local_start <= 1'b1;
    repeat (10) @(negedge pclk);
    chk("local_ignored", 32'h0, {31'h0, motor_accel});
    @(posedge pclk);
    want_start <= 1'b1;
    local_start <= 1'b0;
    wait_lvl("restart", 0, 1'b1, 30);
    @(posedge pclk);
    mains_ok <= 1'b0;
    // Start opened so only a kept run request could resume
    want_start <= 1'b0;
    repeat (60) @(posedge pclk);
    mains_ok <= 1'b1;
    wait_lvl("long_outage", 1, 1'b1, 20);
    chk("no_resume", 32'h0, {31'h0, motor_accel});
    apb(1'b0, 8'h0C, 32'h0);
    r0 = rd;
    n = 1 + int'(rnd() % 3);
    pulses = 0;
    repeat (n) i_host.press_reset();
    chk("pulses", n, pulses);
    apb(1'b0, 8'h0C, 32'h0);
    chk("rcnt", (r0 + n) & 32'hFFFF, rd);
    fault_active <= 1'b1;
    warning_active <= 1'b1;
    want_start <= 1'b0;
    repeat (10) @(negedge pclk);
    chk("alarm_rel", 32'h2, {30'h0, relays.alarm});
    chk("warn_rel", 32'h2, {30'h0, relays.warning});
    @(posedge pclk);
    want_start <= 1'b1;
    repeat (30) @(negedge pclk);
    chk("alarm_block", 32'h0, {31'h0, motor_accel});
    @(posedge pclk);
    fault_active <= 1'b0;
    // Start opened so the local test below is not a leftover start
    want_start <= 1'b0;
    i_host.press_reset();
    panel_remote <= 1'b0;
    local_stop <= 1'b0;
    local_start <= 1'b1;
    wait_lvl("local", 0, 1'b1, 30);
    chk("remote_off", 32'h1, {30'h0, relays.remote});
    // Interlock setting lets the stop contact act outside remote
    apb(1'b1, 8'h00, 32'hF);
    want_stop <= 1'b1;
    wait_lvl("interlock", 1, 1'b1, 30);
    @(posedge pclk);
    want_stop <= 1'b0;
    local_start <= 1'b0;
    // Let the stop release pass the debounce first
    repeat (8) @(posedge pclk);
    apb(1'b1, 8'h04, 32'h1);
    wait_lvl("ser_start", 0, 1'b1, 30);
    apb(1'b0, 8'h08, 32'h0);
    chk("stat", 32'hD1, rd);
    apb(1'b1, 8'h04, 32'h2);
    wait_lvl("ser_stop", 1, 1'b1, 30);
    summarize();
  end
endmodule
